/* pkg/pwr_regs_params.svh */
`ifndef PWR_REGS_PARAMS_SVH
`define PWR_REGS_PARAMS_SVH

// register indices (byte address = index * 4)
`define IDX_SELFTEST_BYTE0 8'h0C
`define IDX_SELFTEST_BYTE1 8'h0D
`define IDX_SELFTEST_BYTE2 8'h0E
`define IDX_SELFTEST_BYTE3 8'h0F
`define IDX_SELFTEST_TRIGGER 8'h10
`define IDX_BUTTON 8'h12
`define IDX_RUN_DELAY 8'h13
`define IDX_REST1_FRAME_PERIOD 8'h14
`define IDX_REST1_DELAY 8'h15
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
`define IDX_MODE 8'h22

`define RST_RUN_DELAY 8'h04
`define RST_REST1_FRAME_PERIOD 8'h01
`define RST_REST1_DELAY 8'h1F
`define RST_SELFTEST 8'h00

`define BTN_STATE_BIT 0
`define BTN_FALL_LSB 4
`define BTN_RISE_LSB 6

`define RUN_FRAMES_PER_UNIT 8
`define REST1_FRAMES_PER_UNIT 16
`define SYS_CLK_HZ 25000000
`define RUN_FRAME_MS 8
`define HIB_CLK_HZ 100
`define PCLK_HZ 100000000

`define IRQ_BIT_REST1 0
`define IRQ_BIT_REST2 1
`define IRQ_BIT_BTN 2
`define IRQ_BIT_SELFTEST 3
`define IRQ_W 4

`endif

/* pkg/pwr_regs_pkg.sv */
package pwr_regs_pkg;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_REST1 = 2'b01,
    MODE_REST2 = 2'b10
  } pwr_mode_e;
endpackage : pwr_regs_pkg

/* design/tick_div.sv */
`timescale 1ns/1ps
// divides pclk into a one-cycle tick every DIV cycles
module tick_div #(
  parameter int DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } st_s;
  st_s q, d;
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (restart) begin
      d.cnt = 32'h0;
    end else if (q.cnt == 32'(DIV - 1)) begin
      d.cnt = 32'h0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign tick = q.tick;
endmodule : tick_div

/* design/power_downshift_button_selftest_regs.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "pwr_regs_params.svh"
// How it works
// [RL1] four read-only self-test result bytes, 0x0c-0x0f
// [RL2] write-only trigger at 0x10 launches self-test
// [RL3] button bit 0 shows current button
// [RL4] bits 7:6 count button rising edges
// [RL5] bits 5:4 count button falling edges
// [RL6] any write restarts counters, data dropped
// [RL7] run to rest1 after count*8 run frames
// [RL8] run frame timing from 25 MHz clock; code counts pclk cycles at PCLK_HZ (100 MHz) instead
// [RL9] rest1 frame period (field+1)*10 ms
// [RL10] rest timing from 100 Hz hibernate clock; code divides pclk by PCLK_HZ / HIB_CLK_HZ instead
// [RL11] rest1 to rest2 after count*16 rest1 frames
// [RL12] motion returns to run, restarts timers
// [RL13] host keeps counts within documented limits
module power_downshift_button_selftest_regs #(
  parameter int RUN_FRAME_CYCLES = `PCLK_HZ / 1000 * `RUN_FRAME_MS,
  parameter int HIB_TICK_CYCLES = `PCLK_HZ / `HIB_CLK_HZ,
  parameter int SELFTEST_CYCLES = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic button_in,
  input wire logic motion_in,
  input wire logic [31:0] selftest_result_in,
  output logic selftest_busy,
  output logic frame_strobe,
  output logic [1:0] power_mode,
  output logic irq
);
  typedef struct packed {
    logic [7:0] sel_byte0;
    logic [7:0] sel_byte1;
    logic [7:0] sel_byte2;
    logic [7:0] sel_byte3;
    logic st_busy;
    logic [7:0] st_cnt;
    logic btn_q;
    logic [1:0] rise_cnt;
    logic [1:0] fall_cnt;
    logic [7:0] run_delay;
    logic [7:0] rest1_frame_period;
    logic [7:0] rest1_delay;
    pwr_regs_pkg::pwr_mode_e mode;
    logic [7:0] frame_cnt;
    logic [7:0] hib_cnt;
    logic [15:0] unit_cnt;
    logic frame;
    logic [`IRQ_W-1:0] irq_stat;
    logic [`IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    logic err;
  } st_s;

  st_s q, d;
  logic run_tick;
  logic hib_tick;
  logic setup;
  logic access;
  logic mapped;
  logic [9:0] idx;
  logic [`IRQ_W-1:0] ev;

  // run frames and hibernate ticks restart with motion so the downshift window is exact
  tick_div #(.DIV(RUN_FRAME_CYCLES)) u_run_div ( // RL8
    .pclk(pclk),
    .presetn(presetn),
    .restart(motion_in),
    .tick(run_tick)
  );
  tick_div #(.DIV(HIB_TICK_CYCLES)) u_hib_div ( // RL10
    .pclk(pclk),
    .presetn(presetn),
    .restart(motion_in),
    .tick(hib_tick)
  );

  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign access = psel && penable;

  always_comb begin
    unique case (idx[7:0])
      `IDX_SELFTEST_BYTE0, `IDX_SELFTEST_BYTE1, `IDX_SELFTEST_BYTE2, `IDX_SELFTEST_BYTE3,
      `IDX_SELFTEST_TRIGGER, `IDX_BUTTON, `IDX_RUN_DELAY, `IDX_REST1_FRAME_PERIOD, `IDX_REST1_DELAY,
      `IDX_IRQ_STATUS, `IDX_IRQ_MASK, `IDX_MODE: mapped = (idx[9:8] == 2'b00);
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    ev = '0;
    d.frame = 1'b0;

    // button edges
    d.btn_q = button_in; // RL3
    if (button_in && !q.btn_q) begin
      d.rise_cnt = q.rise_cnt + 2'h1; // RL4
      ev[`IRQ_BIT_BTN] = 1'b1;
    end
    if (!button_in && q.btn_q) begin
      d.fall_cnt = q.fall_cnt + 2'h1; // RL5
      ev[`IRQ_BIT_BTN] = 1'b1;
    end

    // self-test run
    if (q.st_busy) begin
      if (q.st_cnt == 8'(SELFTEST_CYCLES - 1)) begin
        d.st_busy = 1'b0;
        d.sel_byte0 = selftest_result_in[7:0]; // RL1
        d.sel_byte1 = selftest_result_in[15:8];
        d.sel_byte2 = selftest_result_in[23:16];
        d.sel_byte3 = selftest_result_in[31:24];
        ev[`IRQ_BIT_SELFTEST] = 1'b1;
      end else begin
        d.st_cnt = q.st_cnt + 8'h1;
      end
    end

    // power mode sequencing
    if (motion_in) begin
      d.mode = pwr_regs_pkg::MODE_RUN; // RL12
      d.frame_cnt = 8'h0;
      d.hib_cnt = 8'h0;
      d.unit_cnt = 16'h0;
    end else begin
      unique case (q.mode)
        pwr_regs_pkg::MODE_RUN: begin
          if (run_tick) begin
            d.frame = 1'b1;
            if (q.unit_cnt + 16'h1 >= 16'(q.run_delay) * 16'(`RUN_FRAMES_PER_UNIT)) begin // RL7
              d.mode = pwr_regs_pkg::MODE_REST1;
              d.unit_cnt = 16'h0;
              d.hib_cnt = 8'h0;
              ev[`IRQ_BIT_REST1] = 1'b1;
            end else begin
              d.unit_cnt = q.unit_cnt + 16'h1;
            end
          end
        end
        pwr_regs_pkg::MODE_REST1: begin
          if (hib_tick) begin // RL10
            if (q.hib_cnt >= q.rest1_frame_period) begin // RL9
              d.hib_cnt = 8'h0;
              d.frame = 1'b1;
              if (q.unit_cnt + 16'h1 >= 16'(q.rest1_delay) * 16'(`REST1_FRAMES_PER_UNIT)) begin // RL11
                d.mode = pwr_regs_pkg::MODE_REST2;
                d.unit_cnt = 16'h0;
                ev[`IRQ_BIT_REST2] = 1'b1;
              end else begin
                d.unit_cnt = q.unit_cnt + 16'h1;
              end
            end else begin
              d.hib_cnt = q.hib_cnt + 8'h1;
            end
          end
        end
        pwr_regs_pkg::MODE_REST2: begin
          d.unit_cnt = 16'h0;
        end
        default: begin
          d.mode = pwr_regs_pkg::MODE_RUN;
        end
      endcase
    end

    // apb access phase, one wait-free cycle
    d.err = 1'b0;
    d.rdata = 32'h0;
    if (access) begin
      d.err = !mapped;
      if (pwrite && mapped) begin
        unique case (idx[7:0])
          `IDX_SELFTEST_TRIGGER: begin
            if (!q.st_busy) begin
              d.st_busy = 1'b1; // RL2
              d.st_cnt = 8'h0;
            end
          end
          `IDX_BUTTON: begin
            d.rise_cnt = 2'h0; // RL6
            d.fall_cnt = 2'h0;
          end
          `IDX_RUN_DELAY: if (pstrb[0]) d.run_delay = pwdata[7:0];
          `IDX_REST1_FRAME_PERIOD: if (pstrb[0]) d.rest1_frame_period = pwdata[7:0];
          `IDX_REST1_DELAY: if (pstrb[0]) d.rest1_delay = pwdata[7:0];
          `IDX_IRQ_MASK: if (pstrb[0]) d.irq_mask = pwdata[`IRQ_W-1:0];
          `IDX_IRQ_STATUS: if (pstrb[0]) d.irq_stat = q.irq_stat & ~pwdata[`IRQ_W-1:0];
          default: d.err = 1'b0;
        endcase
      end
    end
    // setup phase prepares read data so it is a flop output during access
    if (setup && !pwrite) begin
      unique case (idx[7:0])
        `IDX_SELFTEST_BYTE0: d.rdata = {24'h0, q.sel_byte0}; // RL1
        `IDX_SELFTEST_BYTE1: d.rdata = {24'h0, q.sel_byte1};
        `IDX_SELFTEST_BYTE2: d.rdata = {24'h0, q.sel_byte2};
        `IDX_SELFTEST_BYTE3: d.rdata = {24'h0, q.sel_byte3};
        `IDX_BUTTON: d.rdata = {24'h0, d.rise_cnt, d.fall_cnt, 3'h0, q.btn_q};
        `IDX_RUN_DELAY: d.rdata = {24'h0, q.run_delay};
        `IDX_REST1_FRAME_PERIOD: d.rdata = {24'h0, q.rest1_frame_period};
        `IDX_REST1_DELAY: d.rdata = {24'h0, q.rest1_delay};
        `IDX_IRQ_STATUS: d.rdata = {28'h0, q.irq_stat};
        `IDX_IRQ_MASK: d.rdata = {28'h0, q.irq_mask};
        `IDX_MODE: d.rdata = {29'h0, q.st_busy, q.mode};
        default: d.rdata = 32'h0;
      endcase
    end
    // set wins over a same-cycle clear
    d.irq_stat = d.irq_stat | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.sel_byte3 <= `RST_SELFTEST;
      q.run_delay <= `RST_RUN_DELAY;
      q.rest1_frame_period <= `RST_REST1_FRAME_PERIOD;
      q.rest1_delay <= `RST_REST1_DELAY;
      q.mode <= pwr_regs_pkg::MODE_RUN;
    end else begin
      q <= d;
    end
  end

  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = access && !mapped;
  assign selftest_busy = q.st_busy;
  assign frame_strobe = q.frame;
  assign power_mode = q.mode;
  assign irq = |(q.irq_stat & q.irq_mask);
endmodule : power_downshift_button_selftest_regs

/* tb/apb_host.sv */
`timescale 1ns/1ps
// apb master on the host side
module apb_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_host

/* tb/pwr_regs_properties.sv */
`timescale 1ns/1ps
module pwr_regs_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic motion_in,
  input wire logic selftest_busy,
  input wire logic frame_strobe,
  input wire logic [1:0] power_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_idle_data: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("read data outside access");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
  a_trig_busy: assert property (psel && penable && pwrite && paddr[11:2] == 10'h010 && !selftest_busy
    |=> selftest_busy) else $error("trigger did not start test");
  a_busy_bound: assert property ($rose(selftest_busy) |-> ##[2:6] !selftest_busy) else $error("test too long");
  a_motion_run: assert property (motion_in |=> power_mode == 2'h0) else $error("motion kept rest");
  a_mode_step: assert property ($changed(power_mode) && power_mode != 2'h0
    |-> power_mode == $past(power_mode) + 2'h1) else $error("mode skipped");
  a_rest2_hold: assert property (power_mode == 2'h2 && !motion_in |=> power_mode == 2'h2) else $error("rest2 left");
  a_strobe_pulse: assert property (frame_strobe |=> !frame_strobe) else $error("frame strobe too long");
endmodule : pwr_regs_properties
bind power_downshift_button_selftest_regs pwr_regs_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .motion_in(motion_in), .selftest_busy(selftest_busy), .frame_strobe(frame_strobe), .power_mode(power_mode));

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic button_in = 1'b0;
  logic motion_in = 1'b0;
  logic [31:0] selftest_result_in = 32'h0;
  logic psel, penable, pwrite, pready, pslverr, selftest_busy, frame_strobe, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] power_mode;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  int f;
  always #5 pclk = ~pclk;
  power_downshift_button_selftest_regs #(.RUN_FRAME_CYCLES(4), .HIB_TICK_CYCLES(3), .SELFTEST_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_in(button_in),
    .motion_in(motion_in), .selftest_result_in(selftest_result_in), .selftest_busy(selftest_busy),
    .frame_strobe(frame_strobe), .power_mode(power_mode), .irq(irq));
  apb_host u_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task rdchk(input logic [7:0] idx, input logic [31:0] exp, input string name);
    u_host.xfer(1'b0, idx, 8'h00, rd, err);
    chk(name, exp, rd);
  endtask : rdchk
  task wr(input logic [7:0] idx, input logic [7:0] d);
    u_host.xfer(1'b1, idx, d, rd, err);
  endtask : wr
  task t_reset;
    rdchk(8'h13, 32'h04, "run_delay");
    rdchk(8'h14, 32'h01, "rest1_frame_period");
    rdchk(8'h15, 32'h1F, "rest1_delay");
    rdchk(8'h0F, 32'h00, "result3");
    $display("t_reset done");
  endtask : t_reset
  task t_selftest;
    selftest_result_in <= 32'hA1B2C3D4;
    wr(8'h21, 8'h08);
    wr(8'h10, 8'h5A);
    #1 chk("busy_start", 32'h1, {31'h0, selftest_busy});
    for (n = 0; n < 40 && selftest_busy !== 1'b0; n++) @(posedge pclk);
    #1 chk("irq_set", 32'h1, {31'h0, irq});
    for (int i = 0; i < 4; i++) rdchk(8'h0C + i[7:0], {24'h0, 32'hA1B2C3D4 >> (8 * i)} & 32'hFF, "result");
    wr(8'h0C, 8'hFF);
    rdchk(8'h0C, 32'hD4, "result_ro");
    wr(8'h20, 8'h08);
    #1 chk("irq_clear", 32'h0, {31'h0, irq});
    rdchk(8'h30, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, err});
    $display("t_selftest done");
  endtask : t_selftest
  task t_button;
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      button_in <= ~button_in;
      repeat (3) @(posedge pclk);
    end
    rdchk(8'h12, 32'h91, "button");
    wr(8'h12, 8'hFF);
    rdchk(8'h12, 32'h01, "button_restart");
    $display("t_button done");
  endtask : t_button
  task t_downshift;
    motion_in <= 1'b1;
    wr(8'h13, 8'h02);
    wr(8'h15, 8'h01);
    @(posedge pclk);
    motion_in <= 1'b0;
    f = 0;
    for (n = 0; n < 300 && power_mode !== 2'h1; n++) begin
      @(posedge pclk);
      if (frame_strobe === 1'b1) f++;
    end
    chk("run_frames", 32'h10, f);
    chk("run_downshift", 32'h1, {31'h0, n >= 62 && n <= 68});
    for (n = 0; n < 300 && power_mode !== 2'h2; n++) @(posedge pclk);
    chk("rest1_to_rest2_delay", 32'h1, {31'h0, n >= 92 && n <= 100});
    rdchk(8'h22, 32'h2, "mode_rest2");
    motion_in <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("motion_run", 32'h0, {30'h0, power_mode});
    $display("t_downshift done");
  endtask : t_downshift
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_selftest;
    t_button;
    t_downshift;
    complete_run;
  end
  initial begin
    #60000;
    miscompares++;
    complete_run;
  end
endmodule : tb
